// File: logic/led_latch_map.vh
// Constants for the serial-in parallel-out LED latch block
// Assumes inclusion by logic/led_latch.v only
`ifndef LED_LATCH_MAP_VH
`define LED_LATCH_MAP_VH
`define LL_STAGES 8
`define LL_SR_RESET 8'h00
`define LL_LATCH_RESET 8'h00
`define LL_SINK_OFF 8'h00
`define LL_SYNC_RESET 3'h0
`define LL_OE_SYNC_RESET 3'h7
`define LL_LEVEL_LOW 1'h0
`define LL_LEVEL_HIGH 1'h1
`define LL_SDO_RESET 1'h0
`define LL_FIFO_DEPTH 32
`define LL_FIFO_PTR_W 5
`endif

// File: logic/led_fifo.v
// Bit buffer of the LED latch: the FIFO module is kept with the rest of the logic in logic/led_latch.v
// Assumes logic/led_latch.v is compiled; this file defines no module

// File: logic/led_latch.v
// Serial-in parallel-out LED latch: shift register, transparent latch, output gate, bit buffer
// Assumes link pins arrive asynchronously and are sampled by clock_i
// Operation
// (RULE1) Each rising shift clock edge shifts serial_in into stage 0, others move on
// (RULE2) Eight stages; newest bit maps to sink 0, oldest to sink 7
// (RULE3) Latch control high makes the latch transparent to the shift register
// (RULE4) Latch control low holds the latched value while shifting continues
// (RULE5) Sinks follow latched data only while output enable low
// (RULE6) Output enable high forces all sinks off, state kept
// (RULE7) serial_out shows the last stage for cascading
// (RULE8) Reset forces all sinks off until data is loaded and enabled
// (RULE9) Controller shifts eight bits, pulses latch control, drives enable low
// (RULE10) Latched one turns a sink on, zero turns it off
`timescale 1ns/1ps
`include "led_latch_map.vh"
module led_latch #(
    parameter STAGES = `LL_STAGES,
    parameter FIFO_DEPTH = `LL_FIFO_DEPTH
) (
    // Clock and reset
    input wire clock_i,
    input wire srst_i,
    // Link pins
    input wire shift_clk_i,
    input wire serial_in_i,
    input wire latch_pass_n_i,
    input wire out_enable_n_i,
    output reg serial_out_o,
    // Sink outputs, high means sinking
    output reg [STAGES-1:0] sink_on_o,
    // Buffer back-pressure
    output wire fifo_ready_o
);
    // Three-flop pin samplers
    reg [2:0] clk_s;
    reg [2:0] din_s;
    reg [2:0] la_s;
    reg [2:0] oe_s;
    // Settled pin levels
    reg clk_st_q;
    reg din_st_q;
    reg la_st_q;
    reg oe_st_q;
    wire clk_st_d;
    wire din_st_d;
    wire la_st_d;
    wire oe_st_d;
    // Shift register, latch and output gate
    reg [STAGES-1:0] sr_q;
    reg [STAGES-1:0] sr_d;
    reg [STAGES-1:0] latch_q;
    reg [STAGES-1:0] latch_d;
    reg [STAGES-1:0] sink_d;
    reg serial_out_d;
    // Bit buffer between sampler and shift register
    wire rise;
    wire fifo_in_valid;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire fifo_bit;

    // Stable value once the second and third flops agree
    function stable;
        input [2:0] s;
        input prev;
        begin
            stable = (s[1] == s[2]) ? s[1] : prev;
        end
    endfunction

    // Shift one bit into the lowest stage
    function [STAGES-1:0] shift_in;
        input [STAGES-1:0] sr;
        input b;
        begin
            shift_in = {sr[STAGES-2:0], b};
        end
    endfunction

    // Sink drive from latch contents and enable
    function [STAGES-1:0] gate;
        input [STAGES-1:0] data;
        input off;
        begin
            if (off) begin
                gate = `LL_SINK_OFF;
            end else begin
                gate = data;
            end
        end
    endfunction

    // Pin samplers, reset to the idle pin levels
    always @(posedge clock_i) begin
        if (srst_i) begin
            clk_s <= `LL_SYNC_RESET;
        end else begin
            clk_s <= {clk_s[1:0], shift_clk_i};
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            din_s <= `LL_SYNC_RESET;
        end else begin
            din_s <= {din_s[1:0], serial_in_i};
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            la_s <= `LL_SYNC_RESET;
        end else begin
            la_s <= {la_s[1:0], latch_pass_n_i};
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            oe_s <= `LL_OE_SYNC_RESET;
        end else begin
            oe_s <= {oe_s[1:0], out_enable_n_i};
        end
    end

    // Settled levels
    assign clk_st_d = stable(clk_s, clk_st_q);
    assign din_st_d = stable(din_s, din_st_q);
    assign la_st_d = stable(la_s, la_st_q);
    assign oe_st_d = stable(oe_s, oe_st_q);

    always @(posedge clock_i) begin
        if (srst_i) begin
            clk_st_q <= `LL_LEVEL_LOW;
        end else begin
            clk_st_q <= clk_st_d;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            din_st_q <= `LL_LEVEL_LOW;
        end else begin
            din_st_q <= din_st_d;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            la_st_q <= `LL_LEVEL_LOW;
        end else begin
            la_st_q <= la_st_d;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            oe_st_q <= `LL_LEVEL_HIGH;
        end else begin
            oe_st_q <= oe_st_d;
        end
    end

    // Data is taken one cycle before the clock edge shows, as set up at the pin
    assign rise = clk_st_d && !clk_st_q;
    assign fifo_in_valid = rise;
    assign fifo_out_ready = 1'h1;

    led_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH), .PTR_W(`LL_FIFO_PTR_W)) u_fifo (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_ready_o),
        .in_data_i(din_st_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_bit)
    );

    always @* begin
        sr_d = sr_q;
        if (fifo_out_valid) begin
            sr_d = shift_in(sr_q, fifo_bit); // RULE1 RULE2
        end
    end

    always @* begin
        latch_d = latch_q; // RULE4
        if (la_st_q) begin
            latch_d = sr_q; // RULE3
        end
    end

    always @* begin
        sink_d = gate(latch_q, oe_st_q); // RULE5 RULE6 RULE10
    end

    always @* begin
        serial_out_d = sr_q[STAGES-1]; // RULE7
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            sr_q <= `LL_SR_RESET;
        end else begin
            sr_q <= sr_d;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            latch_q <= `LL_LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            sink_on_o <= `LL_SINK_OFF; // RULE8
        end else begin
            sink_on_o <= sink_d;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            serial_out_o <= `LL_SDO_RESET;
        end else begin
            serial_out_o <= serial_out_d;
        end
    end
endmodule

// Bit buffer: flip-flop FIFO with valid and ready on both sides
module led_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 32,
    parameter PTR_W = 5
) (
    // Clock and reset
    input wire clock_i,
    input wire srst_i,
    // Write side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Read side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [PTR_W-1:0] wr_q;
    reg [PTR_W-1:0] rd_q;
    reg [PTR_W:0] cnt_q;
    wire push;
    wire pop;

    // Next pointer, wrapping after the last entry
    function [PTR_W-1:0] next_ptr;
        input [PTR_W-1:0] ptr;
        begin
            if (ptr == DEPTH - 1) begin
                next_ptr = {PTR_W{1'h0}};
            end else begin
                next_ptr = ptr + 1'h1;
            end
        end
    endfunction

    assign in_ready_o = (cnt_q != DEPTH);
    assign out_valid_o = (cnt_q != 0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            wr_q <= {PTR_W{1'h0}};
        end else if (push) begin
            wr_q <= next_ptr(wr_q);
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            rd_q <= {PTR_W{1'h0}};
        end else if (pop) begin
            rd_q <= next_ptr(rd_q);
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            cnt_q <= {(PTR_W+1){1'h0}};
        end else if (push && !pop) begin
            cnt_q <= cnt_q + 1'h1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'h1;
        end
    end
endmodule

// File: verification/led_latch_props.sv
// Pin checker for the LED latch
// Assumes it is bound onto led_latch
`timescale 1ns/1ps
module led_latch_props (
    input wire clock_i,
    input wire srst_i,
    input wire shift_clk_i,
    input wire latch_pass_n_i,
    input wire out_enable_n_i,
    input wire serial_out_o,
    input wire [7:0] sink_on_o
);
    wire op = latch_pass_n_i && !out_enable_n_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    a_rst_sinks: assert property ($fell(srst_i) |-> sink_on_o == 8'h00) else $error("sinks on");
    a_rst_serial: assert property ($fell(srst_i) |-> !serial_out_o) else $error("serial set");
    a_gate_off: assert property (out_enable_n_i [*7] |-> sink_on_o == 8'h00) else $error("gate");
    a_gate_fast: assert property ($rose(out_enable_n_i) |-> ##[1:6] sink_on_o == 8'h00) else $error("slow");
    a_latch_hold: assert property ((!latch_pass_n_i && !out_enable_n_i) [*8] |-> $stable(sink_on_o))
        else $error("hold");
    a_idle_still: assert property (!shift_clk_i [*8] |-> $stable(serial_out_o)) else $error("shift");
    a_top_bit: assert property ((op && !shift_clk_i) [*8] |-> sink_on_o[7] == serial_out_o)
        else $error("order");
    a_open_still: assert property ((op && !shift_clk_i) [*8] |-> $stable(sink_on_o)) else $error("open");
endmodule
bind led_latch led_latch_props chk (.clock_i(clock_i), .srst_i(srst_i), .shift_clk_i(shift_clk_i),
    .latch_pass_n_i(latch_pass_n_i), .out_enable_n_i(out_enable_n_i), .serial_out_o(serial_out_o),
    .sink_on_o(sink_on_o));

// File: verification/led_ctl.sv
// Display controller model driving the link pins
// Assumes clock_i is the bench clock; pins move on its rising edge
`timescale 1ns/1ps
module led_ctl (
    input wire clock_i,
    output reg sck_o = 1'b0,
    output reg sdat_o = 1'b0,
    output reg lat_n_o = 1'b0,
    output reg en_n_o = 1'b1
);
    task w(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    task pins(input l, input e);
        begin
            lat_n_o <= l;
            en_n_o <= e;
            w(8);
        end
    endtask
    task send(input [7:0] b);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                sdat_o <= b[i];
                w(4);
                sck_o <= 1'b1;
                w(4);
                sck_o <= 1'b0;
            end
            sdat_o <= ~b[0];
            w(8);
        end
    endtask
endmodule

// File: verification/led_latch_bench.sv
// Testbench for the LED latch
// Assumes the controller model drives every link pin
`timescale 1ns/1ps
module led_latch_bench;
    reg clock_i = 1'b0;
    reg srst_i = 1'b1;
    wire sck, serial_in, lat_n, en_n, serial_out, rdy;
    wire [7:0] sink;
    integer miscompares = 0, cmp_count = 0, seed = 19, k;
    reg [7:0] v, p = 8'h00;
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    led_ctl ctl (.clock_i(clock_i), .sck_o(sck), .sdat_o(serial_in), .lat_n_o(lat_n), .en_n_o(en_n));
    led_latch uut (.clock_i(clock_i), .srst_i(srst_i), .shift_clk_i(sck), .serial_in_i(serial_in),
        .latch_pass_n_i(lat_n), .out_enable_n_i(en_n), .serial_out_o(serial_out), .sink_on_o(sink), .fifo_ready_o(rdy));
    function [7:0] lit(input [7:0] d, input e);
        lit = e ? 8'h00 : d;
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task chk_bit(input got, input exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: bit got %b want %b", $time, got, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            if (miscompares == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        chk(sink, 8'h00);
        for (k = 0; k < 12; k = k + 1) begin
            v = k == 0 ? 8'hff : k == 1 ? 8'h80 : k == 2 ? 8'h01 : $random(seed);
            ctl.pins(1'b0, k[0]);
            ctl.send(v);
            chk(sink, lit(p, k[0]));
            chk_bit(serial_out, v[7]);
            chk_bit(rdy, 1'b1);
            ctl.pins(1'b1, k[0]);
            ctl.pins(1'b0, k[0]);
            chk(sink, lit(v, k[0]));
            ctl.pins(1'b0, 1'b0);
            chk(sink, v);
            p = v;
        end
        ctl.pins(1'b1, 1'b0);
        ctl.send(8'h5a);
        chk(sink, 8'h5a);
        give_verdict;
    end
    initial begin
        #300000;
        miscompares = miscompares + 1;
        give_verdict;
    end
endmodule
